// ### include/smc_pkg.sv
// Purpose: shared types and constants for the sleep mode clock gating controller
// Assumes: one system clock, synchronous active-high reset
// Notes:   mode codes are a plain 3-bit select driven by the core
package smc_pkg;

	// ------------------------------------------------------------
	// sleep mode select codes
	// ------------------------------------------------------------
	localparam logic [2:0] SMC_MODE_IDLE    = 3'h0;
	localparam logic [2:0] SMC_MODE_ADCNR   = 3'h1;
	localparam logic [2:0] SMC_MODE_PDOWN   = 3'h2;
	localparam logic [2:0] SMC_MODE_PSAVE   = 3'h3;
	localparam logic [2:0] SMC_MODE_STBY    = 3'h6;
	localparam logic [2:0] SMC_MODE_XSTBY   = 3'h7;
	localparam logic [2:0] SMC_MODE_RESET   = 3'h0;

	// ------------------------------------------------------------
	// clock enable bundle
	// ------------------------------------------------------------
	typedef struct packed {
		logic cpu;    // processor clock
		logic io;     // sram, timers, spi, general i/o
		logic intr;   // interrupt logic
		logic adc;    // converter clock
		logic atmr;   // asynchronous timer clock
		logic osc;    // main oscillator run
	} smc_clk_en_t;

	localparam smc_clk_en_t SMC_EN_ALL = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ### hw/smc_sleep_ctrl.sv
// Purpose: sleep controller, gates clock domains per selected sleep mode
// Assumes: core raises a one-cycle sleep request; wake sources are same-clock or pre-synced
// Notes:   interrupt logic stays awake in every mode so wake can always be seen
//          reset acts as a wake too: every domain comes back on
//
// How it works
// - idle stops processor clock, keeps sram, timers, spi and interrupts clocked
// - power-down stops oscillator and all functions until interrupt or reset
// - power-save keeps asynchronous timer counting while the rest sleeps
// - adc noise reduction keeps only asynchronous timer, converter and main oscillator running
// - standby keeps main oscillator running, everything else asleep
// - extended standby keeps main oscillator and asynchronous timer running
// - six distinct modes, each selected by software
`timescale 1ns/1ps
module smc_sleep_ctrl
	import smc_pkg::*;
(
	input  wire logic        i_mclk,        // system clock, 200 MHz
	input  wire logic        i_srst,        // synchronous reset, active high
	input  wire logic [2:0]  i_mode_sel,    // sleep mode chosen by software
	input  wire logic        i_sleep_en,    // software sleep enable
	input  wire logic        i_sleep_req,   // one-cycle sleep instruction pulse
	input  wire logic        i_wake_irq,    // enabled wake interrupt, same clock
	output smc_clk_en_t      o_clk_en,      // per-domain clock enables
	output logic             o_asleep,      // high while in a sleep mode
	output logic             o_mode_bad     // pulse: request with unused code
);

	// two states are enough, the mode itself lives in mode_reg
	typedef enum logic [0:0] {SMC_ST_RUN, SMC_ST_SLEEP} smc_state_t;

	// state, captured mode and registered enables
	smc_state_t  state_reg;
	logic [2:0]  mode_reg;
	smc_clk_en_t en_reg;
	smc_clk_en_t en_next;
	logic        go;
	logic        bad_reg;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	// one decode table so every gate comes from the same place
	function automatic smc_clk_en_t smc_mode_en(input logic [2:0] m);
		smc_clk_en_t e;
		e = SMC_EN_ALL;
		case (m)
			SMC_MODE_IDLE: begin
				e.cpu = 1'b0;
			end
			SMC_MODE_ADCNR: begin
				e = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
			end
			SMC_MODE_PDOWN: begin
				e = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
			end
			SMC_MODE_PSAVE: begin
				e = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
			end
			SMC_MODE_STBY: begin
				e = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
			end
			SMC_MODE_XSTBY: begin
				e = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
			end
			default: begin
				e = SMC_EN_ALL;
			end
		endcase
		return e;
	endfunction

	// valid codes are exactly the six modes
	function automatic logic smc_mode_ok(input logic [2:0] m);
		return (m != 3'h4) && (m != 3'h5);
	endfunction

	// a sleep request only counts when enabled, legal, and no wake pending
	assign go = i_sleep_en && i_sleep_req && smc_mode_ok(i_mode_sel) && !i_wake_irq;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	// wake wins over entering sleep, so a racing interrupt is never lost
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_reg <= SMC_ST_RUN;
		end else begin
			case (state_reg)
				SMC_ST_RUN: begin
					if (go) begin
						state_reg <= SMC_ST_SLEEP;
					end
				end
				SMC_ST_SLEEP: begin
					if (i_wake_irq) begin
						state_reg <= SMC_ST_RUN;
					end
				end
				default: begin
					state_reg <= SMC_ST_RUN;
				end
			endcase
		end
	end

	// captured mode, so a change of select while asleep does nothing
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			mode_reg <= SMC_MODE_RESET;
		end else if (go && state_reg == SMC_ST_RUN) begin
			mode_reg <= i_mode_sel;
		end
	end

	// ------------------------------------------------------------
	// clock enables
	// ------------------------------------------------------------
	// next enables: mode table on entry, everything back on at wake
	always_comb begin
		en_next = en_reg;
		if (state_reg == SMC_ST_RUN && go) begin
			en_next = smc_mode_en(i_mode_sel);
		end else if (state_reg == SMC_ST_SLEEP && i_wake_irq) begin
			en_next = SMC_EN_ALL;
		end
	end

	// registered enables, glitch-free for the clock gate cells
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			en_reg <= SMC_EN_ALL;
		end else begin
			en_reg <= en_next;
		end
	end

	// unused code flagged, request dropped
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			bad_reg <= 1'b0;
		end else begin
			bad_reg <= i_sleep_en && i_sleep_req && !smc_mode_ok(i_mode_sel);
		end
	end

	// outputs straight from registers or a state compare
	assign o_clk_en   = en_reg;
	assign o_asleep   = (state_reg == SMC_ST_SLEEP);
	assign o_mode_bad = bad_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	// per-mode gating, judged against the mode captured at entry
	a_idle_gates: assert property (
		o_asleep && mode_reg == SMC_MODE_IDLE |->
		!o_clk_en.cpu && o_clk_en.io && o_clk_en.intr)
		else $error("idle gating wrong");
	a_pdown_stop: assert property (
		o_asleep && mode_reg == SMC_MODE_PDOWN |->
		!o_clk_en.osc && !o_clk_en.io && !o_clk_en.atmr && !o_clk_en.adc)
		else $error("power-down not fully stopped");
	a_psave_timer: assert property (
		o_asleep && mode_reg == SMC_MODE_PSAVE |-> o_clk_en.atmr && !o_clk_en.io)
		else $error("power-save timer gating wrong");
	a_adcnr_keep: assert property (
		o_asleep && mode_reg == SMC_MODE_ADCNR |->
		o_clk_en.adc && o_clk_en.atmr && !o_clk_en.io && !o_clk_en.cpu)
		else $error("adc noise gating wrong");
	a_stby_osc: assert property (
		o_asleep && mode_reg == SMC_MODE_STBY |-> o_clk_en.osc && !o_clk_en.atmr)
		else $error("standby oscillator gating wrong");
	a_xstby_both: assert property (
		o_asleep && mode_reg == SMC_MODE_XSTBY |-> o_clk_en.osc && o_clk_en.atmr)
		else $error("extended standby gating wrong");
	a_bad_mode: assert property (
		i_sleep_en && i_sleep_req && !smc_mode_ok(i_mode_sel) && !o_asleep
		|=> !o_asleep && o_mode_bad)
		else $error("unused mode entered sleep");
	a_wake_restore: assert property (
		o_asleep && i_wake_irq |=> !o_asleep && o_clk_en == SMC_EN_ALL)
		else $error("wake did not restore clocks");
	a_enter_sleep: assert property (
		!o_asleep && go |=> o_asleep && !o_clk_en.cpu && $stable(o_clk_en.intr))
		else $error("sleep entry failed");

	// domain-wide checks that hold in every mode, not just one
	a_intr_alive: assert property (
		o_clk_en.intr)
		else $error("interrupt clock gated");
	a_asleep_cpu: assert property (
		o_asleep |-> !o_clk_en.cpu)
		else $error("processor clocked in sleep");
	a_mode_legal: assert property (
		o_asleep |-> smc_mode_ok(mode_reg))
		else $error("asleep in unused mode");
	a_bad_quiet: assert property (
		!(i_sleep_en && i_sleep_req) |=> !o_mode_bad)
		else $error("unused mode flag without request");

	// awake means fully clocked, asleep means frozen until a wake
	a_run_all_on: assert property (
		!o_asleep |-> o_clk_en == SMC_EN_ALL)
		else $error("clocks gated while awake");
	a_sleep_hold: assert property (
		o_asleep && !i_wake_irq |=> o_asleep && $stable(o_clk_en))
		else $error("sleep left without wake");
	a_wake_run: assert property (
		!o_asleep && i_wake_irq |=> !o_asleep)
		else $error("slept with a wake pending");

	c_idle:  cover property (o_asleep && mode_reg == SMC_MODE_IDLE ##1 !o_asleep);
	c_pdown: cover property (o_asleep && mode_reg == SMC_MODE_PDOWN ##1 !o_asleep);
	c_xstby: cover property (o_asleep && mode_reg == SMC_MODE_XSTBY);
	c_bad:   cover property (o_mode_bad);
	// power-save entry, the only mode with the timer alone running
	c_psave: cover property (o_asleep && mode_reg == SMC_MODE_PSAVE);

endmodule

// ### verif/smc_dom_model.sv
// Purpose: far-side model, clock domains that run only while enabled
// Assumes: enables sampled on the system clock rising edge
// Notes:   counters wrap; the bench only compares short deltas
`timescale 1ns/1ps
module smc_dom_model
	import smc_pkg::*;
(
	input  wire logic        i_mclk,     // system clock
	input  smc_clk_en_t      i_clk_en,   // gated domain enables
	output logic [7:0]       o_cpu_cnt,  // processor activity count
	output logic [7:0]       o_atmr_cnt  // async timer time base
);
	// --------------------------------------------------------
	// domains advance only while their clock is let through
	// --------------------------------------------------------
	initial o_cpu_cnt = 8'h00;
	initial o_atmr_cnt = 8'h00;
	// plain always: the counters also take a start value from an initial
	always @(posedge i_mclk) begin
		if (i_clk_en.cpu) o_cpu_cnt <= o_cpu_cnt + 8'h01;
		if (i_clk_en.atmr) o_atmr_cnt <= o_atmr_cnt + 8'h01;
	end
endmodule

// ### verif/sleep_mode_clock_gating_tb_top.sv
// Purpose: self-checking bench for the sleep controller
// Assumes: inputs driven by non-blocking assignment on the rising edge
// Notes:   enables compared one cycle after each request edge
`timescale 1ns/1ps
module sleep_mode_clock_gating_tb_top;
	import smc_pkg::*;
	logic clk = 1'b0, srst = 1'b1, en = 1'b0, req = 1'b0, wake = 1'b0, bad, asleep;
	logic [2:0] sel = 3'h0;
	logic [7:0] cc, ca, c0, a0;
	smc_clk_en_t ce;
	int bad_count = 0, checks_done = 0, cyc = 0;
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [5:0] exp [6] = '{6'h1F, 6'h0F, 6'h08, 6'h0A, 6'h09, 6'h0B};
	always #2.5 clk = ~clk;
	smc_sleep_ctrl i_dut (.i_mclk(clk), .i_srst(srst), .i_mode_sel(sel), .i_sleep_en(en),
		.i_sleep_req(req), .i_wake_irq(wake), .o_clk_en(ce), .o_asleep(asleep),
		.o_mode_bad(bad));
	smc_dom_model i_dom (.i_mclk(clk), .i_clk_en(ce), .o_cpu_cnt(cc), .o_atmr_cnt(ca));
	// --------------------------------------------------------
	// shared helpers
	// --------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic pulse(input logic [2:0] m, input logic e, input logic w);
		@(posedge clk);
		sel <= m;
		en <= e;
		req <= 1'b1;
		wake <= w;
		@(posedge clk);
		req <= 1'b0;
		wake <= 1'b0;
		#1;
	endtask
	task automatic wake_up;
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		#1;
		chk({bad, asleep, ce}, {2'b00, SMC_EN_ALL});
	endtask
	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_modes;
		for (int i = 0; i < 6; i++) begin
			pulse(codes[i], 1'b1, 1'b0);
			chk({asleep, ce}, {1'b1, exp[i]});
			c0 = cc;
			a0 = ca;
			repeat (3) @(posedge clk);
			#1;
			chk({cc - c0, ca - a0}, {8'h00, exp[i][1] ? 8'h03 : 8'h00});
			wake_up();
		end
	endtask
	task automatic t_refuse;
		pulse(3'h4, 1'b1, 1'b0);
		chk({bad, asleep}, 2'b10);
		pulse(3'h5, 1'b1, 1'b0);
		chk({bad, asleep}, 2'b10);
		pulse(3'h2, 1'b0, 1'b0);
		chk({bad, asleep}, 2'b00);
		pulse(3'h2, 1'b1, 1'b1);
		chk({asleep, ce}, {1'b0, SMC_EN_ALL});
	endtask
	task automatic t_reset_wake;
		pulse(3'h2, 1'b1, 1'b0);
		pulse(3'h0, 1'b1, 1'b0);
		chk({asleep, ce}, {1'b1, 6'h08});
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		#1;
		chk({asleep, ce}, {1'b0, SMC_EN_ALL});
		pulse(3'h7, 1'b1, 1'b0);
		chk({asleep, ce}, {1'b1, 6'h0B});
		wake_up();
	endtask
	// --------------------------------------------------------
	// run, timeout and verdict
	// --------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_modes();
		t_refuse();
		t_reset_wake();
		results();
	end
endmodule
